// *** include/i2c_master_restart_ctrl_map.svh ***
// Constants for the I2C master sequencing block.
// Assumes a 100 MHz system clock; included by the package only.
`ifndef I2C_MASTER_RESTART_CTRL_MAP_SVH
`define I2C_MASTER_RESTART_CTRL_MAP_SVH

// ------------------------------------------------------------
// Second control register bit positions
// ------------------------------------------------------------
`define CTL2_START_BIT 0
`define CTL2_RESTART_BIT 1
`define CTL2_STOP_BIT 2
`define CTL2_ACK_STAT_BIT 6
`define CTL2_LOW_MASK 8'h1f

// ------------------------------------------------------------
// Status and reload fields
// ------------------------------------------------------------
`define STAT_START_SEEN_BIT 3
`define RELOAD_WIDTH 7
`define RELOAD_RESET 7'h31
`define CTL2_RESET 8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 10

`endif

// *** include/i2c_master_restart_ctrl_pkg.sv ***
// Types shared by the I2C master sequencing block.
// Assumes the map header is on the include path.
package i2c_master_restart_ctrl_pkg;
  `include "i2c_master_restart_ctrl_map.svh"

  // ------------------------------------------------------------
  // Pin quartet, output enable low means driving low
  // ------------------------------------------------------------
  typedef struct packed {
    logic sda_o;
    logic sda_oe_n;
    logic scl_o;
    logic scl_oe_n;
  } i2c_pins_t;

  // ------------------------------------------------------------
  // Software request strobes
  // ------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic restart;
    logic stop;
    logic ack_req;
    logic ack_val;
  } ctl_req_t;

  typedef enum logic [4:0] {
    ST_IDLE,
    ST_START_A,
    ST_START_B,
    ST_BIT_LOW,
    ST_BIT_HIGH,
    ST_BIT_END,
    ST_RS_LOW,
    ST_RS_SDA,
    ST_RS_SCLH,
    ST_RS_SDAL,
    ST_STOP_A,
    ST_STOP_B,
    ST_STOP_C,
    ST_HOLD
  } mstate_t;
endpackage

// *** design/baud_gen.sv ***
// Baud period down-counter giving one-cycle expiry pulses.
// Assumes load has priority over counting; single clock domain.
module baud_gen
  import i2c_master_restart_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_load,
  input wire logic i_run,
  input wire logic [`RELOAD_WIDTH-1:0] i_reload,
  // Expiry
  output logic o_tick
);
  logic [`RELOAD_WIDTH-1:0] cnt_reg;
  wire expire = i_run && (cnt_reg == '0);

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_reg <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= expire && !i_load;
      if (i_load || expire)
        cnt_reg <= i_reload;
      else if (i_run)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

// *** design/i2c_master_restart_ctrl.sv ***
// I2C master sequencer: start, repeated start, stop, byte shift, clock hold.
// Assumes synchronous pins, open-drain wiring outside, software via plain ports.
module i2c_master_restart_ctrl
  import i2c_master_restart_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Bus pins sampled
  input wire logic i_sda,
  input wire logic i_scl,
  // Software control
  input wire logic i_master_en,
  input wire logic i_clock_release_bit,
  input wire ctl_req_t i_req,
  input wire logic i_ctl2_we,
  input wire logic i_buf_we,
  input wire logic [7:0] i_buf_wdata,
  input wire logic i_recv_req,
  input wire logic [`RELOAD_WIDTH-1:0] i_baud_reload,
  input wire logic i_flag_clr,
  input wire logic i_write_collision_flag_clr,
  input wire logic i_bcol_clr,
  // Pin drive
  output i2c_pins_t o_pins,
  // Status
  output logic [7:0] o_ctl2,
  output logic [7:0] o_status,
  output logic [7:0] o_rx_data,
  output logic o_port_interrupt_flag,
  output logic o_write_collision_flag,
  output logic o_bus_collision
);
  import i2c_master_restart_ctrl_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  mstate_t st_reg;
  mstate_t st_next;
  logic [7:0] shift_reg;
  logic [3:0] bit_reg;
  logic rx_reg;
  logic sda_drv_low_reg;
  logic scl_drv_low_reg;
  logic sda_prev_reg;
  logic scl_prev_reg;
  logic bg_load;
  logic bg_run;
  logic bg_tick;

  baud_gen u_baud
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(bg_load),
    .i_run(bg_run),
    .i_reload(i_baud_reload),
    .o_tick(bg_tick)
  );

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire idle = (st_reg == ST_IDLE) || (st_reg == ST_HOLD);
  wire rs_busy = (st_reg == ST_RS_LOW) || (st_reg == ST_RS_SDA)
    || (st_reg == ST_RS_SCLH) || (st_reg == ST_RS_SDAL);
  wire busy = !idle;
  wire ctl_ok = i_ctl2_we && !rs_busy && i_master_en;
  wire go_restart = ctl_ok && i_req.restart && idle;
  wire go_start = ctl_ok && i_req.start && (st_reg == ST_IDLE) && !go_restart;
  wire go_stop = ctl_ok && i_req.stop && idle && !go_restart && !go_start;
  wire buf_coll = i_buf_we && (rs_busy || (busy && st_reg != ST_HOLD));
  wire go_tx = i_buf_we && !buf_coll && (st_reg == ST_HOLD);
  wire go_rx = i_recv_req && (st_reg == ST_HOLD) && !i_buf_we;
  wire bus_start = scl_prev_reg && i_scl && sda_prev_reg && !i_sda;
  wire bus_stop = scl_prev_reg && i_scl && !sda_prev_reg && i_sda;
  wire scl_rise = !scl_prev_reg && i_scl;
  wire scl_fall = scl_prev_reg && !i_scl;
  wire rs_coll = ((st_reg == ST_RS_SDA) && scl_rise && !i_sda)
    || ((st_reg == ST_RS_SCLH || st_reg == ST_RS_SDA) && scl_fall && !scl_drv_low_reg)
    || ((st_reg == ST_RS_SCLH) && !i_sda);
  // clock hold only once SCL seen low
  wire hold_ok = !i_clock_release_bit && !i_scl;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    bg_load = 1'b0;
    bg_run = busy;
    case (st_reg)
      ST_IDLE, ST_HOLD:
      begin
        bg_run = 1'b0;
        if (go_start)
        begin
          st_next = ST_START_A;
          bg_load = 1'b1;
        end
        else if (go_restart)
          st_next = ST_RS_LOW;
        else if (go_stop)
        begin
          st_next = ST_STOP_A;
          bg_load = 1'b1;
        end
        else if (go_tx || go_rx)
        begin
          st_next = ST_BIT_LOW;
          bg_load = 1'b1;
        end
      end
      ST_START_A: if (bg_tick) st_next = ST_START_B;
      ST_START_B: if (bg_tick) st_next = ST_HOLD;
      // each half bit is one baud period
      ST_BIT_LOW: if (bg_tick) st_next = ST_BIT_HIGH;
      ST_BIT_HIGH: if (bg_tick && i_scl) st_next = ST_BIT_END;
      // Eight data clocks plus the acknowledge clock
      ST_BIT_END: st_next = (bit_reg == 4'h9) ? ST_HOLD : ST_BIT_LOW;
      ST_RS_LOW:
      begin
        bg_run = 1'b0;
        if (!i_scl)
        begin
          bg_load = 1'b1;
          st_next = ST_RS_SDA;
        end
      end
      // wait SDA high then release SCL
      ST_RS_SDA: if (bg_tick && i_sda) st_next = ST_RS_SCLH;
      ST_RS_SCLH:
      begin
        if (!i_scl)
          bg_load = 1'b1;
        else if (bg_tick)
          st_next = ST_RS_SDAL;
      end
      ST_RS_SDAL: if (bg_tick) st_next = ST_HOLD;
      ST_STOP_A: if (bg_tick) st_next = ST_STOP_B;
      ST_STOP_B: if (bg_tick && i_scl) st_next = ST_STOP_C;
      ST_STOP_C: if (bg_tick) st_next = ST_IDLE;
      default: st_next = ST_IDLE;
    endcase
    if (rs_coll)
    begin
      st_next = ST_IDLE;
      bg_load = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Line drive, decided from next state so pins come from flops
  // ------------------------------------------------------------
  wire tx_bit = shift_reg[7];
  // Data holds through the high phase end, else SCL high would see a stop
  wire shifting = (st_next == ST_BIT_LOW) || (st_next == ST_BIT_HIGH) || (st_next == ST_BIT_END);
  wire sda_low_next = (st_next == ST_START_B) || (st_next == ST_RS_SDAL)
    || (st_next == ST_STOP_A) || (st_next == ST_STOP_B)
    || (st_next == ST_HOLD && st_reg != ST_STOP_C && sda_drv_low_reg && !shifting)
    || (shifting && !rx_reg && bit_reg < 4'h8 && !tx_bit)
    || (shifting && rx_reg && bit_reg == 4'h8 && !i_req.ack_val);
  // clock hold and master low phases
  wire scl_low_next = (st_next == ST_BIT_LOW) || (st_next == ST_RS_LOW) || (st_next == ST_RS_SDA)
    || (st_next == ST_STOP_A) || (st_next == ST_HOLD)
    || (st_next == ST_IDLE && (hold_ok || (scl_drv_low_reg && !i_clock_release_bit)));

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_reg <= ST_IDLE;
      sda_drv_low_reg <= 1'b0;
      scl_drv_low_reg <= 1'b0;
      sda_prev_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
      sda_drv_low_reg <= sda_low_next;
      scl_drv_low_reg <= scl_low_next;
      sda_prev_reg <= i_sda;
      scl_prev_reg <= i_scl;
    end
  end

  // pins driven only by this master sequencer
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_pins <= '{sda_o: 1'b0, sda_oe_n: 1'b1, scl_o: 1'b0, scl_oe_n: 1'b1};
    else
      o_pins <= '{sda_o: 1'b0, sda_oe_n: !sda_low_next, scl_o: 1'b0, scl_oe_n: !scl_low_next};
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      shift_reg <= 8'h00;
      bit_reg <= 4'h0;
      rx_reg <= 1'b0;
      o_rx_data <= 8'h00;
    end
    else if (go_tx || go_rx)
    begin
      shift_reg <= go_tx ? i_buf_wdata : 8'hff;
      rx_reg <= go_rx;
      bit_reg <= 4'h0;
    end
    else if (st_reg == ST_BIT_HIGH && st_next == ST_BIT_END)
    begin
      if (bit_reg < 4'h8)
        shift_reg <= {shift_reg[6:0], i_sda};
      bit_reg <= bit_reg + 4'h1;
    end
    else if (st_reg == ST_BIT_END && bit_reg == 4'h9 - 4'h1 && rx_reg)
      o_rx_data <= shift_reg;
  end

  // ------------------------------------------------------------
  // Control and status bits
  // ------------------------------------------------------------
  wire start_end = (st_reg == ST_START_B) && (st_next == ST_HOLD);
  wire rs_end = (st_reg == ST_RS_SDAL) && (st_next == ST_HOLD);
  wire byte_end = (st_reg == ST_BIT_END) && (bit_reg == 4'h9);
  wire stop_end = (st_reg == ST_STOP_C) && (st_next == ST_IDLE);
  wire ack_cap = (st_reg == ST_BIT_HIGH) && (st_next == ST_BIT_END) && (bit_reg == 4'h8) && !rx_reg;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_ctl2 <= `CTL2_RESET;
    else
    begin
      o_ctl2[`CTL2_RESTART_BIT] <= (o_ctl2[`CTL2_RESTART_BIT] || go_restart) && !rs_end && !rs_coll;
      o_ctl2[`CTL2_START_BIT] <= (o_ctl2[`CTL2_START_BIT] || go_start) && !start_end;
      o_ctl2[`CTL2_STOP_BIT] <= (o_ctl2[`CTL2_STOP_BIT] || go_stop) && !stop_end;
      o_ctl2[4:3] <= ctl_ok ? {i_req.ack_req, i_req.ack_val} : o_ctl2[4:3];
      if (ack_cap)
        o_ctl2[`CTL2_ACK_STAT_BIT] <= i_sda;
    end
  end

  // Set wins over clear for every sticky flag
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_port_interrupt_flag <= 1'b0;
      o_write_collision_flag <= 1'b0;
      o_bus_collision <= 1'b0;
      o_status <= 8'h00;
    end
    else
    begin
      o_port_interrupt_flag <= (start_end || rs_end || byte_end || stop_end)
        || (o_port_interrupt_flag && !i_flag_clr);
      o_write_collision_flag <= buf_coll || (o_write_collision_flag && !i_write_collision_flag_clr);
      o_bus_collision <= rs_coll || (o_bus_collision && !i_bcol_clr);
      if (bus_start)
        o_status[`STAT_START_SEEN_BIT] <= 1'b1;
      else if (bus_stop)
        o_status[`STAT_START_SEEN_BIT] <= 1'b0;
      o_status[0] <= busy;
    end
  end
endmodule

// *** tb/i2c_master_restart_ctrl_props.sv ***
// Concurrent checks on the I2C master sequencer ports.
// Assumes binding to the top module; one clock domain.
module i2c_master_restart_ctrl_props
  import i2c_master_restart_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Inputs watched
  input wire logic i_sda,
  input wire logic i_scl,
  input wire logic i_master_en,
  input wire logic i_clock_release_bit,
  input wire i2c_master_restart_ctrl_pkg::ctl_req_t i_req,
  input wire logic i_ctl2_we,
  input wire logic i_buf_we,
  // Outputs watched
  input wire i2c_master_restart_ctrl_pkg::i2c_pins_t o_pins,
  input wire logic [7:0] o_ctl2,
  input wire logic [7:0] o_status,
  input wire logic o_port_interrupt_flag,
  input wire logic o_write_collision_flag,
  input wire logic o_bus_collision
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // --------
  // Sequences
  // --------
  sequence slave_low;
    !i_master_en && !i_clock_release_bit && !i_scl;
  endsequence
  sequence bus_start;
    $fell(i_sda) && i_scl && $past(i_scl);
  endsequence
  // --------
  // Checks
  // --------
  chk_scl_forced: assert property (slave_low [*2] |=> !o_pins.scl_oe_n)
    else $error("scl not held low");
  chk_no_own_pull: assert property ($fell(o_pins.scl_oe_n) && !i_master_en |-> !$past(i_scl))
    else $error("scl pulled while high");
  chk_hold_stays: assert property (!i_master_en && !i_clock_release_bit && !o_pins.scl_oe_n |=> !o_pins.scl_oe_n)
    else $error("held scl let go");
  chk_rs_busy: assert property (o_ctl2[0] && i_ctl2_we && i_req.restart |=> !o_ctl2[1])
    else $error("restart taken while busy");
  chk_rs_lock: assert property (o_ctl2[1] && i_ctl2_we |=> !o_ctl2[2] && !o_ctl2[0])
    else $error("control write during restart");
  chk_write_collision_flag_set: assert property (o_ctl2[1] && i_buf_we |=> o_write_collision_flag)
    else $error("write collision missed");
  chk_rs_sda_low: assert property ($fell(o_ctl2[1]) && !o_bus_collision |-> !o_pins.sda_oe_n)
    else $error("sda not held after restart");
  chk_rs_scl_high: assert property (o_ctl2[1] && $fell(o_pins.sda_oe_n) |-> o_pins.scl_oe_n)
    else $error("sda fell with scl low");
  chk_start_irq: assert property ($fell(o_ctl2[0]) && !o_bus_collision |-> ##[0:1] o_port_interrupt_flag)
    else $error("no flag after start");
  chk_stop_irq: assert property ($fell(o_ctl2[2]) && !o_bus_collision |-> ##[0:1] o_port_interrupt_flag)
    else $error("no flag after stop");
  chk_rs_irq: assert property ($rose(o_port_interrupt_flag) |-> !o_ctl2[1])
    else $error("flag during restart");
  chk_start_seen: assert property (bus_start |-> ##[1:3] (o_status[3] || o_bus_collision))
    else $error("start not seen");
  chk_bcol_free: assert property ($rose(o_bus_collision) |-> ##[0:1] (o_pins.sda_oe_n && o_pins.scl_oe_n))
    else $error("lines kept after collision");
endmodule

bind i2c_master_restart_ctrl i2c_master_restart_ctrl_props props (
  .i_clk, .i_rst, .i_sda, .i_scl, .i_master_en, .i_clock_release_bit, .i_req, .i_ctl2_we, .i_buf_we,
  .o_pins, .o_ctl2, .o_status, .o_port_interrupt_flag, .o_write_collision_flag, .o_bus_collision);

// *** tb/i2c_slave_model.sv ***
// Behavioural I2C slave: captures written bytes and acknowledges them.
// Assumes wired-AND bus levels built by the bench.
module i2c_slave_model
(
  // Clock and bus
  input wire logic i_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  // Control
  input wire logic i_ack_en,
  output logic o_sda_low,
  output logic [7:0] o_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  int f = 0;
  initial o_sda_low = 1'b0;
  initial o_byte = 8'h00;
  always @(posedge i_clk)
  begin
    if (scl_q && i_scl && sda_q && !i_sda)
      f = -1;
    if (!scl_q && i_scl && f >= 0 && f < 8)
      o_byte <= {o_byte[6:0], i_sda};
    if (scl_q && !i_scl)
    begin
      f = f + 1;
      o_sda_low <= (f == 8) && i_ack_en;
      if (f == 9)
        f = 0;
    end
    scl_q = i_scl;
    sda_q = i_sda;
  end
endmodule

// *** tb/test_i2c_master_restart_ctrl.sv ***
// Self-checking bench for the I2C master sequencer.
// Assumes package, checker and slave model compile first.
`define CHK(nm, ex, got) \
  begin \
    n_compared++; \
    if ((got) !== (ex)) \
    begin \
      bad_count++; \
      $display("MISMATCH %s exp %h got %h", nm, ex, got); \
    end \
  end
module test_i2c_master_restart_ctrl;
  import i2c_master_restart_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rst, master_en, rel_bit, ctl2_we, buf_we, flag_clr, write_collision_flag_clr, bcol_clr;
  logic tb_sda_low, tb_scl_low, ack_en, slv_low, sda_bus, scl_bus, irq, write_collision_flag, bcol;
  logic [7:0] wdata, slv_byte, ctl2, status, rx_data;
  logic recv_req;
  logic [6:0] reload;
  ctl_req_t req;
  i2c_pins_t pins;
  int bad_count = 0;
  int n_compared = 0;
  int seed = 32'h2db3893f;
  int rnd, k;
  // Open-drain lines with pull-ups
  assign sda_bus = pins.sda_oe_n & ~slv_low & ~tb_sda_low;
  assign scl_bus = pins.scl_oe_n & ~tb_scl_low;
  i2c_master_restart_ctrl DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_sda(sda_bus), .i_scl(scl_bus), .i_master_en(master_en),
    .i_clock_release_bit(rel_bit), .i_req(req), .i_ctl2_we(ctl2_we), .i_buf_we(buf_we),
    .i_buf_wdata(wdata), .i_recv_req(recv_req), .i_baud_reload(reload), .i_flag_clr(flag_clr),
    .i_write_collision_flag_clr(write_collision_flag_clr), .i_bcol_clr(bcol_clr), .o_pins(pins), .o_ctl2(ctl2), .o_status(status),
    .o_rx_data(rx_data), .o_port_interrupt_flag(irq), .o_write_collision_flag(write_collision_flag), .o_bus_collision(bcol));
  i2c_slave_model slave (.i_clk(i_clk), .i_scl(scl_bus), .i_sda(sda_bus), .i_ack_en(ack_en),
    .o_sda_low(slv_low), .o_byte(slv_byte));
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  function automatic logic [7:0] addr_byte(input logic [6:0] a, input logic rd);
    return {a, rd};
  endfunction
  task automatic wrap_up;
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bound(input int n);
    if (n >= 3000)
    begin
      bad_count++;
      wrap_up();
    end
  endtask
  task automatic wait_flag;
    int n = 0;
    while (irq !== 1'b1 && n < 3000)
    begin
      @(negedge i_clk);
      n++;
    end
    bound(n);
  endtask
  task automatic ctl(input logic s, input logic r, input logic p);
    @(negedge i_clk);
    req = '{start: s, restart: r, stop: p, ack_req: 1'b0, ack_val: 1'b0};
    ctl2_we = 1'b1;
    flag_clr = 1'b1;
    @(negedge i_clk);
    ctl2_we = 1'b0;
    flag_clr = 1'b0;
  endtask
  task automatic send(input logic [7:0] b, input logic ack);
    ack_en = ack;
    @(negedge i_clk);
    wdata = b;
    buf_we = 1'b1;
    flag_clr = 1'b1;
    @(negedge i_clk);
    buf_we = 1'b0;
    flag_clr = 1'b0;
    wait_flag();
    `CHK("tx byte", b, slv_byte)
    `CHK("ack stat", ~ack, ctl2[6])
  endtask
  initial
  begin
    {i_rst, tb_sda_low, tb_scl_low, master_en, rel_bit} = 5'h10;
    {ctl2_we, buf_we, flag_clr, write_collision_flag_clr, bcol_clr, ack_en} = 6'h01;
    req = '0;
    recv_req = 1'b0;
    wdata = 8'h00;
    rnd = $random(seed);
    reload = 7'h02 + {5'h00, rnd[1:0]};
    repeat (20) @(negedge i_clk);
    i_rst = 1'b0;
    // Slave-side clock hold
    repeat (3) @(negedge i_clk);
    `CHK("scl idle", 1'b1, pins.scl_oe_n)
    tb_scl_low = 1'b1;
    repeat (3) @(negedge i_clk);
    tb_scl_low = 1'b0;
    repeat (3) @(negedge i_clk);
    `CHK("scl held", 1'b0, scl_bus)
    rel_bit = 1'b1;
    repeat (3) @(negedge i_clk);
    `CHK("scl freed", 1'b1, scl_bus)
    master_en = 1'b1;
    // Start with a restart refused mid-way
    ctl(1'b1, 1'b0, 1'b0);
    ctl(1'b0, 1'b1, 1'b0);
    `CHK("rs busy", 1'b0, ctl2[1])
    wait_flag();
    `CHK("start sda", 1'b0, sda_bus)
    `CHK("start seen", 1'b1, status[3])
    `CHK("scl hold", 1'b0, scl_bus)
    rnd = $random(seed);
    send(addr_byte(rnd[6:0], 1'b0), 1'b1);
    send(8'hff, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      rnd = $random(seed);
      send(rnd[15:8], rnd[16]);
    end
    // Restart with blocked writes inside it
    ctl(1'b0, 1'b1, 1'b0);
    `CHK("rs taken", 1'b1, ctl2[1])
    buf_we = 1'b1;
    @(negedge i_clk);
    buf_we = 1'b0;
    `CHK("write_collision_flag", 1'b1, write_collision_flag)
    ctl(1'b0, 1'b0, 1'b1);
    `CHK("ctl2 lock", 1'b0, ctl2[2])
    wait_flag();
    `CHK("rs clear", 1'b0, ctl2[1])
    `CHK("rs sda", 1'b0, sda_bus)
    `CHK("rs seen", 1'b1, status[3])
    write_collision_flag_clr = 1'b1;
    send(addr_byte(rnd[6:0], 1'b1), 1'b1);
    write_collision_flag_clr = 1'b0;
    // Receive one byte; the slave leaves SDA released for the eight data bits
    @(negedge i_clk);
    recv_req = 1'b1;
    flag_clr = 1'b1;
    @(negedge i_clk);
    recv_req = 1'b0;
    flag_clr = 1'b0;
    wait_flag();
    `CHK("rx byte", 8'hff, rx_data)
    ctl(1'b0, 1'b0, 1'b1);
    wait_flag();
    `CHK("stop sda", 1'b1, sda_bus)
    `CHK("stop scl", 1'b1, scl_bus)
    // Collision: SDA pulled low once SCL is released in a restart
    ctl(1'b1, 1'b0, 1'b0);
    wait_flag();
    ctl(1'b0, 1'b1, 1'b0);
    for (k = 0; pins.scl_oe_n !== 1'b1 && k < 3000; k++)
      @(negedge i_clk);
    bound(k);
    tb_sda_low = 1'b1;
    for (k = 0; bcol !== 1'b1 && k < 3000; k++)
      @(negedge i_clk);
    bound(k);
    @(negedge i_clk);
    `CHK("bcol sda", 1'b1, pins.sda_oe_n)
    `CHK("bcol scl", 1'b1, pins.scl_oe_n)
    `CHK("bcol rs", 1'b0, ctl2[1])
    tb_sda_low = 1'b0;
    wrap_up();
  end
endmodule
